// ===== verilog/cmc_charger_mode_control.v
// charger mode control: apb registers, watchdog, source mode, charge cycle
//
// The placing of the registers and the APB slave port were left to the implementer.
`default_nettype none
`include "cmc_defs.vh"
module cmc_charger_mode_control #(
  parameter TICK_CYC = `CMC_TICK_CYC
) (
  input  wire        clk_i,                  // 100 MHz clock
  input  wire        rst_n_i,                // async reset, active low
  input  wire        psel_i,                 // apb select
  input  wire        penable_i,              // apb enable
  input  wire        pwrite_i,               // apb write
  input  wire [7:0]  paddr_i,                // apb byte address
  input  wire [31:0] pwdata_i,               // apb write data
  output wire [31:0] prdata_o,               // apb read data
  output wire        pready_o,               // apb ready
  output wire        pslverr_o,              // apb error, unmapped
  input  wire        source_select_pin_i,    // high usb port, low adapter
  input  wire        charge_enable_pin_n_i,  // low enables charging
  input  wire        input_good_i,           // input source qualified
  input  wire [12:0] vbat_mv_i,              // battery voltage, mV
  input  wire [12:0] vin_mv_i,               // input voltage, mV
  input  wire [12:0] vsys_mv_i,              // system rail, mV
  input  wire [11:0] ichg_ma_i,              // measured charge current
  input  wire        therm_chg_ok_i,         // thermistor in charge range
  input  wire        therm_src_ok_i,         // thermistor between hot/cold
  input  wire        in_regulation_i,        // input or thermal regulation
  output wire        converter_en_o,         // buck switching enabled
  output wire        battery_switch_o,       // battery switch on
  output wire [5:0]  iin_limit_o,            // applied limit, 100 mA units
  output wire [12:0] vin_floor_mv_o,         // applied input floor, mV
  output wire        pulse_skip_o,           // pulse-skipping allowed
  output wire        source_mode_o,          // source (boost) active
  output wire        source_pwm_o,           // source in fixed frequency
  output wire        source_current_sel_o,   // source current select
  output wire [11:0] charge_current_ma_o,    // charge current target
  output wire [12:0] charge_voltage_mv_o,    // charge voltage target
  output wire        charge_indicator_pin_o, // low while charging
  output wire        host_event_pin_n_o      // low pulse per event
);
  localparam ST_OFF   = 3'd0;
  localparam ST_PRE   = 3'd1;
  localparam ST_FAST  = 3'd2;
  localparam ST_DONE  = 3'd3;
  localparam ST_FAULT = 3'd4;
  localparam [31:0] TICK_LAST = TICK_CYC - 1;
  localparam integer EVT_CYC_I = `CMC_EVT_CYC;
  localparam [7:0]  EVT_CYC   = EVT_CYC_I[7:0];

  // ----------------------------------------------------------------
  // pin synchronisers and millisecond tick
  // ----------------------------------------------------------------
  reg [1:0]  psel_sync_reg;
  reg [1:0]  ce_sync_reg;
  reg [31:0] tick_cnt_reg;
  reg        tick_reg;
  always @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      psel_sync_reg <= 2'b00;
      ce_sync_reg   <= 2'b11;
      tick_cnt_reg  <= 32'h0;
      tick_reg      <= 1'b0;
    end else begin
      psel_sync_reg <= {psel_sync_reg[0], source_select_pin_i};
      ce_sync_reg   <= {ce_sync_reg[0], charge_enable_pin_n_i};
      tick_reg      <= (tick_cnt_reg == TICK_LAST);
      tick_cnt_reg  <= (tick_cnt_reg == TICK_LAST) ? 32'h0
                       : tick_cnt_reg + 32'h1;
    end
  end
  wire psel_s = psel_sync_reg[1];
  wire ce_n_s = ce_sync_reg[1];

  // ----------------------------------------------------------------
  // registers, watchdog and mode
  // ----------------------------------------------------------------
  reg [15:0] ctrl_reg;
  reg [5:0]  iin_code_reg;
  reg [3:0]  vfl_code_reg;
  reg [5:0]  ichg_code_reg;
  reg [3:0]  iterm_code_reg;
  reg [3:0]  ipre_code_reg;
  reg [7:0]  vreg_code_reg;
  reg        host_mode_reg;
  reg [17:0] wdt_cnt_reg;
  reg        init_done_reg;
  reg        psel_prev_reg;
  reg        pready_reg;
  reg        pslverr_reg;
  reg [31:0] prdata_reg;

  wire apb_setup = psel_i & ~penable_i;
  wire apb_wr    = psel_i & penable_i & pwrite_i & pready_reg;
  wire wr_ctrl   = apb_wr & (paddr_i == `CMC_OFF_CTRL);
  wire wr_limit  = apb_wr & (paddr_i == `CMC_OFF_LIMIT);
  wire wr_chg    = apb_wr & (paddr_i == `CMC_OFF_CHARGE);
  wire mapped    = (paddr_i == `CMC_OFF_CTRL) | (paddr_i == `CMC_OFF_LIMIT)
                 | (paddr_i == `CMC_OFF_CHARGE)
                 | (paddr_i == `CMC_OFF_STATUS);
  wire kick      = wr_ctrl & pwdata_i[`CMC_CTRL_KICK];
  wire [1:0] wdt_per  = ctrl_reg[`CMC_CTRL_PER_LO+1:`CMC_CTRL_PER_LO];
  wire [1:0] stat_cfg = ctrl_reg[`CMC_CTRL_STAT_LO+1:`CMC_CTRL_STAT_LO];
  wire [1:0] trk_sel  = ctrl_reg[`CMC_CTRL_TRK_LO+1:`CMC_CTRL_TRK_LO];
  wire       llm_dis  = ctrl_reg[`CMC_CTRL_LLM_DIS];
  wire       bsw_off  = ctrl_reg[`CMC_CTRL_BSW_OFF];
  reg  [17:0] wdt_limit;
  always @* begin
    case (wdt_per)
      2'b01:   wdt_limit = `CMC_WDT1_MS;
      2'b10:   wdt_limit = `CMC_WDT2_MS;
      default: wdt_limit = `CMC_WDT3_MS;
    endcase
  end
  wire wdt_expire = host_mode_reg & (wdt_per != 2'b00) & tick_reg
                  & (wdt_cnt_reg >= wdt_limit - 18'd1);
  wire [4:0] vfl_wr = pwdata_i[12:8];

  always @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      ctrl_reg       <= `CMC_CTRL_RST;
      iin_code_reg   <= `CMC_IIN_RST;
      vfl_code_reg   <= `CMC_VFL_RST;
      ichg_code_reg  <= `CMC_ICHG_RST;
      iterm_code_reg <= `CMC_ITERM_RST;
      ipre_code_reg  <= `CMC_IPRE_RST;
      vreg_code_reg  <= `CMC_VREG_RST;
      host_mode_reg  <= 1'b0;
      wdt_cnt_reg    <= 18'h0;
      init_done_reg  <= 1'b0;
      psel_prev_reg  <= 1'b0;
    end else begin
      if (wdt_expire) begin
        // current limit, floor and battery switch bits survive expiry
        host_mode_reg  <= 1'b0;
        ctrl_reg       <= (`CMC_CTRL_RST & ~`CMC_CTRL_KEEP)
                          | (ctrl_reg & `CMC_CTRL_KEEP);
        ichg_code_reg  <= `CMC_ICHG_RST;
        iterm_code_reg <= `CMC_ITERM_RST;
        ipre_code_reg  <= `CMC_IPRE_RST;
        vreg_code_reg  <= `CMC_VREG_RST;
        wdt_cnt_reg    <= 18'h0;
      end else begin
        // host writes apply in either mode
        if (wr_ctrl)
          ctrl_reg <= pwdata_i[15:0] & `CMC_CTRL_WMASK;
        if (kick) begin
          host_mode_reg <= 1'b1;
          wdt_cnt_reg   <= 18'h0;
        end else if (host_mode_reg && wdt_per != 2'b00 && tick_reg)
          wdt_cnt_reg <= wdt_cnt_reg + 18'h1;
        if (wr_chg) begin
          ichg_code_reg  <= pwdata_i[5:0];
          iterm_code_reg <= pwdata_i[11:8];
          ipre_code_reg  <= pwdata_i[15:12];
          vreg_code_reg  <= pwdata_i[23:16];
        end
        if (wr_limit)
          vfl_code_reg <= vfl_wr[4] ? 4'hF
                          : vfl_wr[3:0];
        // in default mode the select pin reloads the limit after reset and on each change
        if (!host_mode_reg && (!init_done_reg || psel_s != psel_prev_reg))
          iin_code_reg <= psel_s ? `CMC_IIN_USB : `CMC_IIN_RST;
        else if (wr_limit)
          iin_code_reg <= pwdata_i[5:0];
      end
      init_done_reg <= 1'b1;
      psel_prev_reg <= psel_s;
    end
  end

  // ----------------------------------------------------------------
  // converter, input limits and light-load mode
  // ----------------------------------------------------------------
  reg        conv_reg;
  reg        bsw_reg;
  reg [5:0]  iin_out_reg;
  reg [12:0] vfl_out_reg;
  reg        psk_reg;
  reg        src_reg;
  reg        src_pwm_reg;
  reg [4:0]  src_dly_reg;
  reg [4:0]  src_pfm_reg;
  wire chg_req = ctrl_reg[`CMC_CTRL_CHG_EN] & ~ce_n_s
               & (ichg_code_reg != 6'h0) & ~bsw_off;
  wire [12:0] vfl_mv = `CMC_VFL_BASE_MV
                     + {9'h0, vfl_code_reg} * `CMC_VFL_STEP_MV;
  reg  [13:0] trk_off;
  always @* begin
    case (trk_sel)
      2'b01:   trk_off = `CMC_TRK1_MV;
      2'b10:   trk_off = `CMC_TRK2_MV;
      2'b11:   trk_off = `CMC_TRK3_MV;
      default: trk_off = 14'd0;
    endcase
  end
  wire [13:0] trk_mv  = {1'b0, vbat_mv_i} + trk_off;
  wire [12:0] trk_sat = trk_mv[13] ? 13'h1FFF : trk_mv[12:0];
  wire [13:0] sleep_mv = {1'b0, vbat_mv_i} + `CMC_SLEEP_MV;
  wire src_ok = ctrl_reg[`CMC_CTRL_SRC_EN] & therm_src_ok_i
              & (vbat_mv_i > `CMC_SRC_MIN_MV)
              & ({1'b0, vin_mv_i} < sleep_mv)
              & (src_dly_reg == `CMC_SRC_DLY_MS);
  wire src_pfm_done = llm_dis | (src_pfm_reg == `CMC_SRC_PFM_MS);

  always @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      conv_reg    <= 1'b0;
      bsw_reg     <= 1'b1;
      iin_out_reg <= `CMC_IIN_SS;
      vfl_out_reg <= 13'h0;
      psk_reg     <= 1'b0;
      src_reg     <= 1'b0;
      src_pwm_reg <= 1'b0;
      src_dly_reg <= 5'h0;
      src_pfm_reg <= 5'h0;
    end else begin
      // no switching until the limit was decided after reset
      conv_reg <= input_good_i & init_done_reg & ~src_reg;
      bsw_reg  <= ~bsw_off & (~conv_reg | chg_req);
      if (vsys_mv_i < `CMC_VSYS_SS_MV && iin_code_reg > `CMC_IIN_SS)
        iin_out_reg <= `CMC_IIN_SS;
      else
        iin_out_reg <= iin_code_reg;
      if (trk_sel != 2'b00 && trk_sat > vfl_mv)
        vfl_out_reg <= trk_sat;
      else
        vfl_out_reg <= vfl_mv;
      // enable delay restarts whenever the source enable bit is cleared
      if (!ctrl_reg[`CMC_CTRL_SRC_EN])
        src_dly_reg <= 5'h0;
      else if (tick_reg && src_dly_reg != `CMC_SRC_DLY_MS)
        src_dly_reg <= src_dly_reg + 5'h1;
      src_reg <= src_ok;
      if (!src_reg)
        src_pfm_reg <= 5'h0;
      else if (tick_reg && src_pfm_reg != `CMC_SRC_PFM_MS)
        src_pfm_reg <= src_pfm_reg + 5'h1;
      src_pwm_reg <= src_reg & src_pfm_done;
      psk_reg <= ~llm_dis & (src_reg ? ~src_pfm_done
                 : (iin_code_reg >= `CMC_IIN_PSK_MIN));
    end
  end

  // ----------------------------------------------------------------
  // charge cycle
  // ----------------------------------------------------------------
  reg [2:0]  st_reg;
  reg [2:0]  st_next;
  reg [25:0] safe_cnt_reg;
  reg        half_reg;
  reg        tmr_fault_reg;
  reg [8:0]  blink_cnt_reg;
  reg        blink_reg;
  reg [11:0] ichg_out_reg;
  reg [12:0] vreg_out_reg;
  reg        ind_reg;
  reg [7:0]  evt_cnt_reg;
  reg        evt_n_reg;
  wire [12:0] vreg_mv  = `CMC_VREG_BASE_MV
                       + {5'h0, vreg_code_reg} * `CMC_VREG_STEP_MV;
  wire [12:0] rechg_mv = vreg_mv - (ctrl_reg[`CMC_CTRL_RECHG]
                         ? `CMC_RECHG_HI_MV : `CMC_RECHG_LO_MV);
  wire [11:0] term_ma  = {8'h0, iterm_code_reg} * `CMC_ITERM_STEP_MA;
  wire [11:0] pre_ma   = {8'h0, ipre_code_reg} * `CMC_ITERM_STEP_MA;
  wire [11:0] fast_ma  = {6'h0, ichg_code_reg} * `CMC_ICHG_STEP_MA;
  wire charging  = (st_reg == ST_PRE) | (st_reg == ST_FAST);
  wire safe_hit  = charging & tick_reg & (~in_regulation_i | half_reg)
                 & (safe_cnt_reg == `CMC_SAFETY_MS - 26'd1);
  wire start_ok  = conv_reg & chg_req & therm_chg_ok_i & ~tmr_fault_reg;

  always @* begin
    st_next = st_reg;
    case (st_reg)
      ST_OFF: begin
        if (start_ok)
          st_next = (vbat_mv_i < `CMC_VBAT_LOW_MV) ? ST_PRE
                    : ST_FAST;
      end
      ST_PRE, ST_FAST: begin
        if (!chg_req || !conv_reg)
          st_next = ST_OFF;
        else if (safe_hit || !therm_chg_ok_i)
          st_next = ST_FAULT;
        else if (st_reg == ST_PRE && vbat_mv_i >= `CMC_VBAT_LOW_MV)
          st_next = ST_FAST;
        else if (st_reg == ST_FAST && ichg_ma_i < term_ma
                 && vbat_mv_i > rechg_mv && !in_regulation_i)
          st_next = ST_DONE;
      end
      ST_DONE: begin
        if (!chg_req || !conv_reg || vbat_mv_i < rechg_mv)
          st_next = ST_OFF;
      end
      ST_FAULT: begin
        if (!chg_req || (therm_chg_ok_i && !tmr_fault_reg))
          st_next = ST_OFF;
      end
      default: st_next = ST_OFF;
    endcase
  end
  wire evt = (st_next == ST_DONE && st_reg != ST_DONE)
           | (st_next == ST_FAULT && st_reg != ST_FAULT);

  always @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      st_reg        <= ST_OFF;
      safe_cnt_reg  <= 26'h0;
      half_reg      <= 1'b0;
      tmr_fault_reg <= 1'b0;
      blink_cnt_reg <= 9'h0;
      blink_reg     <= 1'b0;
      ichg_out_reg  <= 12'h0;
      vreg_out_reg  <= 13'h0;
      ind_reg       <= 1'b1;
      evt_cnt_reg   <= 8'h0;
      evt_n_reg     <= 1'b1;
    end else begin
      st_reg <= st_next;
      // a toggle of either enable clears the timer and its fault
      if (!chg_req) begin
        safe_cnt_reg  <= 26'h0;
        tmr_fault_reg <= 1'b0;
      end else if (safe_hit) begin
        tmr_fault_reg <= 1'b1;
        safe_cnt_reg  <= 26'h0;
      end else if (charging && tick_reg) begin
        half_reg <= ~half_reg;
        // regulation halves the timer rate
        if (!in_regulation_i || half_reg)
          safe_cnt_reg <= safe_cnt_reg + 26'h1;
      end
      if (tick_reg) begin
        if (blink_cnt_reg == `CMC_BLINK_MS - 9'd1) begin
          blink_cnt_reg <= 9'h0;
          blink_reg     <= ~blink_reg;
        end else
          blink_cnt_reg <= blink_cnt_reg + 9'h1;
      end
      case (st_next)
        ST_PRE:  ichg_out_reg <= (vbat_mv_i < `CMC_VBAT_SHORT_MV)
                                 ? `CMC_ISHORT_MA : pre_ma;
        ST_FAST: ichg_out_reg <= fast_ma;
        default: ichg_out_reg <= 12'h0;
      endcase
      vreg_out_reg <= vreg_mv;
      if (stat_cfg == 2'b11)
        ind_reg <= 1'b1;
      else if (st_next == ST_FAULT)
        ind_reg <= blink_reg;
      else
        ind_reg <= ~(st_next == ST_PRE || st_next == ST_FAST);
      // an event during a running pulse is merged into it
      if (evt && evt_cnt_reg == 8'h0)
        evt_cnt_reg <= EVT_CYC;
      else if (evt_cnt_reg != 8'h0)
        evt_cnt_reg <= evt_cnt_reg - 8'h1;
      evt_n_reg <= ~((evt && evt_cnt_reg == 8'h0)
                   || evt_cnt_reg > 8'h1);
    end
  end

  // ----------------------------------------------------------------
  // apb answer and status
  // ----------------------------------------------------------------
  reg [1:0] phase;
  always @* begin
    case (st_reg)
      ST_PRE:  phase = 2'b01;
      ST_FAST: phase = 2'b10;
      ST_DONE: phase = 2'b11;
      default: phase = 2'b00;
    endcase
  end
  wire [2:0] in_type = src_reg ? 3'b111
                     : !init_done_reg ? 3'b000
                     : psel_s ? 3'b001 : 3'b011;
  wire [31:0] status = {20'h0, tmr_fault_reg, bsw_reg, conv_reg, psk_reg,
                        src_pwm_reg, src_reg, ~host_mode_reg,
                        phase, in_type};
  reg [31:0] rd_mux;
  always @* begin
    case (paddr_i)
      `CMC_OFF_CTRL:   rd_mux = {16'h0, ctrl_reg};
      `CMC_OFF_LIMIT:  rd_mux = {20'h0, vfl_code_reg, 2'b00, iin_code_reg};
      `CMC_OFF_CHARGE: rd_mux = {8'h0, vreg_code_reg, ipre_code_reg,
                                 iterm_code_reg, 2'b00, ichg_code_reg};
      `CMC_OFF_STATUS: rd_mux = status;
      default:         rd_mux = 32'h0;
    endcase
  end
  always @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      pready_reg  <= 1'b0;
      pslverr_reg <= 1'b0;
      prdata_reg  <= 32'h0;
    end else begin
      pready_reg  <= apb_setup;
      pslverr_reg <= apb_setup & ~mapped;
      prdata_reg  <= (apb_setup & ~pwrite_i) ? rd_mux : 32'h0;
    end
  end

  assign prdata_o               = prdata_reg;
  assign pready_o               = pready_reg;
  assign pslverr_o              = pslverr_reg;
  assign converter_en_o         = conv_reg;
  assign battery_switch_o       = bsw_reg;
  assign iin_limit_o            = iin_out_reg;
  assign vin_floor_mv_o         = vfl_out_reg;
  assign pulse_skip_o           = psk_reg;
  assign source_mode_o          = src_reg;
  assign source_pwm_o           = src_pwm_reg;
  assign source_current_sel_o   = ctrl_reg[14];
  assign charge_current_ma_o    = ichg_out_reg;
  assign charge_voltage_mv_o    = vreg_out_reg;
  assign charge_indicator_pin_o = ind_reg;
  assign host_event_pin_n_o     = evt_n_reg;
endmodule
`default_nettype wire

// ===== verilog/cmc_defs.vh
// register map, field layout, defaults and timing counts of the charger control
`ifndef CMC_DEFS_VH
`define CMC_DEFS_VH
`define CMC_OFF_CTRL      8'h00
`define CMC_OFF_LIMIT     8'h04
`define CMC_OFF_CHARGE    8'h08
`define CMC_OFF_STATUS    8'h0C
`define CMC_CTRL_CHG_EN   0
`define CMC_CTRL_SRC_EN   1
`define CMC_CTRL_LLM_DIS  2
`define CMC_CTRL_KICK     3
`define CMC_CTRL_PER_LO   4
`define CMC_CTRL_STAT_LO  6
`define CMC_CTRL_TRK_LO   8
`define CMC_CTRL_RECHG    10
`define CMC_CTRL_BSW_OFF  11
`define CMC_CTRL_RST      16'h4011
`define CMC_CTRL_WMASK    16'hFFF7
`define CMC_CTRL_KEEP     16'h3800
`define CMC_IIN_RST       6'h18
`define CMC_IIN_USB       6'h05
`define CMC_IIN_SS        6'h02
`define CMC_IIN_PSK_MIN   6'h05
`define CMC_VFL_RST       4'h6
`define CMC_VFL_MAX       5'h0F
`define CMC_VFL_BASE_MV   13'd3900
`define CMC_VFL_STEP_MV   13'd100
`define CMC_ICHG_RST      6'h20
`define CMC_ICHG_STEP_MA  12'd64
`define CMC_ITERM_RST     4'h3
`define CMC_IPRE_RST      4'h3
`define CMC_ITERM_STEP_MA 12'd60
`define CMC_VREG_RST      8'h2C
`define CMC_VREG_BASE_MV  13'd3856
`define CMC_VREG_STEP_MV  13'd8
`define CMC_ISHORT_MA     12'd100
`define CMC_VSYS_SS_MV    13'd2200
`define CMC_VBAT_SHORT_MV 13'd2200
`define CMC_VBAT_LOW_MV   13'd3000
`define CMC_RECHG_LO_MV   13'd100
`define CMC_RECHG_HI_MV   13'd200
`define CMC_TRK1_MV       14'd200
`define CMC_TRK2_MV       14'd250
`define CMC_TRK3_MV       14'd300
`define CMC_SRC_MIN_MV    13'd2900
`define CMC_SLEEP_MV      14'd40
`define CMC_CLK_NS        10
`define CMC_TICK_NS       1000000
`define CMC_TICK_CYC      (`CMC_TICK_NS / `CMC_CLK_NS)
`define CMC_SRC_DLY_MS    5'd30
`define CMC_SRC_PFM_MS    5'd2
`define CMC_WDT1_MS       18'd40000
`define CMC_WDT2_MS       18'd80000
`define CMC_WDT3_MS       18'd160000
`define CMC_SAFETY_MS     26'd36000000
`define CMC_BLINK_MS      9'd500
`define CMC_EVT_NS        1000
`define CMC_EVT_CYC       (`CMC_EVT_NS / `CMC_CLK_NS)
`endif

// ===== bench/cmc_asserts.sv
// checker: bus timing, event pulse and mode control relations
`default_nettype none
module cmc_asserts (
  input wire logic        clk_i,              // clock
  input wire logic        rst_n_i,            // reset
  input wire logic        psel_i,             // select
  input wire logic        penable_i,          // enable
  input wire logic        pready_o,           // ready
  input wire logic        pslverr_o,          // error
  input wire logic        host_event_pin_n_o, // event
  input wire logic        source_mode_o,      // source on
  input wire logic        source_pwm_o,       // fixed freq
  input wire logic        therm_src_ok_i,     // thermistor
  input wire logic [12:0] vsys_mv_i,          // rail
  input wire logic [5:0]  iin_limit_o,        // limit
  input wire logic        converter_en_o,     // converter
  input wire logic        input_good_i        // input ok
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0] low_cnt;
  // length of the running event pulse, reset while the pin is high
  always_ff @(posedge clk_i or negedge rst_n_i)
    if (!rst_n_i) low_cnt <= 8'h00;
    else if (host_event_pin_n_o) low_cnt <= 8'h00;
    else low_cnt <= low_cnt + 8'h01;
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (!rst_n_i);
  sequence s_setup;
    psel_i && !penable_i;
  endsequence
  sequence s_src_start;
    $rose(source_mode_o);
  endsequence
  property p_ready; s_setup |=> pready_o; endproperty
  a_ready: assert property (p_ready)
    else $error("no ready after setup");
  property p_slverr; pslverr_o |-> pready_o; endproperty
  a_slverr: assert property (p_slverr)
    else $error("error without ready");
  property p_evt_end; $rose(host_event_pin_n_o) |-> low_cnt == 8'h64;
  endproperty
  a_evt_end: assert property (p_evt_end)
    else $error("event pulse length wrong");
  property p_evt_max; low_cnt <= 8'h64; endproperty
  a_evt_max: assert property (p_evt_max)
    else $error("event pulse too long");
  property p_iin; (vsys_mv_i < 13'h898) [*2] |-> iin_limit_o <= 6'h02;
  endproperty
  a_iin: assert property (p_iin)
    else $error("limit not capped on low rail");
  property p_src_ok; s_src_start |-> $past(therm_src_ok_i); endproperty
  a_src_ok: assert property (p_src_ok)
    else $error("source started out of temperature");
  property p_src_pfm; s_src_start |-> !source_pwm_o [*8]; endproperty
  a_src_pfm: assert property (p_src_pfm)
    else $error("source began in fixed frequency");
  property p_cnv; $rose(converter_en_o) |-> $past(input_good_i);
  endproperty
  a_cnv: assert property (p_cnv)
    else $error("converter started without input");
endmodule
`default_nettype wire

// ===== bench/cmc_host.sv
// host model: register bus master for the charger control
`default_nettype none
module cmc_host (
  input  wire logic        clk_i,     // clock
  output var  logic        psel_o,    // select
  output var  logic        penable_o, // enable
  output var  logic        pwrite_o,  // direction
  output var  logic [7:0]  paddr_o,   // byte address
  output var  logic [31:0] pwdata_o,  // write data
  input  wire logic [31:0] prdata_i,  // read data
  input  wire logic        pready_i,  // ready
  input  wire logic        pslverr_i  // error
);
  timeunit 1ns;
  timeprecision 1ns;
  initial {psel_o, penable_o, pwrite_o, paddr_o, pwdata_o} = 43'h0;
  // the leading edge keeps release and next setup in separate steps
  task automatic xfer(input logic w, input logic [7:0] a,
                      input logic [31:0] d, output logic [31:0] q,
                      output logic e);
    @(posedge clk_i);
    {psel_o, pwrite_o, paddr_o, pwdata_o} <= {1'b1, w, a, d};
    @(posedge clk_i);
    penable_o <= 1'b1;
    do @(posedge clk_i); while (pready_i !== 1'b1);
    q = prdata_i;
    e = pslverr_i;
    {psel_o, penable_o} <= 2'b00;
  endtask
endmodule
`default_nettype wire

// ===== bench/tb_cmc_charger_mode_control.sv
// testbench: registers, limits, charge cycle, events and source mode
`default_nettype none
module tb_cmc_charger_mode_control;
  timeunit 1ns;
  timeprecision 1ns;
  logic        clk_i = 1'b0, rst_n_i = 1'b0, source_select_pin_i = 1'b0;
  logic        charge_enable_pin_n_i = 1'b0, input_good_i = 1'b1, e, m;
  logic        therm_chg_ok_i = 1'b1, therm_src_ok_i = 1'b1, pready_o;
  logic        in_regulation_i = 1'b0, psel_i, penable_i, pwrite_i;
  logic [7:0]  paddr_i;
  logic [31:0] pwdata_i, prdata_o, q;
  logic [31:0] trk [4] = '{32'h1194, 32'h11F8, 32'h122A, 32'h125C};
  logic [12:0] vbat_mv_i = 13'hDAC, vin_mv_i = 13'h1388, vsys_mv_i = 13'hD48;
  logic [12:0] vin_floor_mv_o, charge_voltage_mv_o;
  logic [11:0] ichg_ma_i = 12'h3E8, charge_current_ma_o;
  logic [5:0]  iin_limit_o;
  logic        pslverr_o, converter_en_o, battery_switch_o, pulse_skip_o;
  logic        source_mode_o, source_pwm_o, source_current_sel_o;
  logic        charge_indicator_pin_o, host_event_pin_n_o;
  int          error_cnt = 0, n_checks = 0, n, cyc_cnt = 0;
  cmc_charger_mode_control #(.TICK_CYC(10)) i_cmc_charger_mode_control (.*);
  cmc_host i_cmc_host (.clk_i(clk_i), .psel_o(psel_i), .penable_o(penable_i),
    .pwrite_o(pwrite_i), .paddr_o(paddr_i), .pwdata_o(pwdata_i),
    .prdata_i(prdata_o), .pready_i(pready_o), .pslverr_i(pslverr_o));
  initial forever #5 clk_i = ~clk_i;
  task automatic report_and_stop;
    $display("checks %0d errors %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  always @(posedge clk_i) begin
    cyc_cnt <= cyc_cnt + 1;
    if (cyc_cnt == 20000) begin
      error_cnt++;
      report_and_stop();
    end
  end
  task automatic chk(input string s, input logic [31:0] g, x);
    n_checks++;
    if (g !== x) begin
      error_cnt++;
      $display("ERROR %s expected %0h seen %0h", s, x, g);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    i_cmc_host.xfer(1'b1, a, d, q, e);
  endtask
  task automatic rd(input logic [7:0] a);
    i_cmc_host.xfer(1'b0, a, 32'h0, q, e);
  endtask
  task automatic cyc(input int c);
    repeat (c) @(posedge clk_i);
  endtask
  // counts the low cycles of the next event pulse
  task automatic evt_len;
    do @(posedge clk_i); while (host_event_pin_n_o !== 1'b0);
    n = 0;
    while (host_event_pin_n_o === 1'b0) begin
      @(posedge clk_i);
      n++;
    end
  endtask
  initial begin
    cyc(5);
    rst_n_i <= 1'b1;
    cyc(10);
    chk("floor", vin_floor_mv_o, 32'h1194);
    chk("ilim", iin_limit_o, 32'h18);
    chk("conv", converter_en_o, 32'h1);
    chk("ichg", charge_current_ma_o, 32'h800);
    chk("vreg", charge_voltage_mv_o, 32'h1070);
    chk("psk", pulse_skip_o, 32'h1);
    chk("ind", charge_indicator_pin_o, 32'h0);
    chk("srcsel", source_current_sel_o, 32'h1);
    rd(8'h00);
    chk("ctrl", q, 32'h4011);
    rd(8'h08);
    chk("charge", q, 32'h2C3320);
    rd(8'h0C);
    chk("status", q, 32'h733);
    rd(8'h10);
    chk("unmapped", {e, q[30:0]}, 32'h80000000);
    source_select_pin_i <= 1'b1;
    cyc(6);
    chk("ilim usb", iin_limit_o, 32'h5);
    source_select_pin_i <= 1'b0;
    vsys_mv_i <= 13'h7D0;
    cyc(6);
    chk("ilim cap", iin_limit_o, 32'h2);
    vsys_mv_i <= 13'hD48;
    wr(8'h04, 32'h1F04);
    cyc(4);
    chk("psk low", pulse_skip_o, 32'h0);
    chk("floor max", vin_floor_mv_o, 32'h1518);
    wr(8'h04, 32'h0618);
    wr(8'h00, 32'h4015);
    cyc(4);
    chk("psk dis", pulse_skip_o, 32'h0);
    vbat_mv_i <= 13'h1130;
    for (int k = 0; k < 4; k++) begin
      wr(8'h00, {16'h0, 6'h10, k[1:0], 8'h11});
      cyc(4);
      chk("track", vin_floor_mv_o, trk[k]);
    end
    vbat_mv_i <= 13'h7D0;
    wr(8'h00, 32'h4010);
    cyc(4);
    chk("bsw off", battery_switch_o, 32'h0);
    chk("ind off", charge_indicator_pin_o, 32'h1);
    rd(8'h0C);
    chk("ph off", q[4:3], 32'h0);
    wr(8'h00, 32'h4011);
    cyc(4);
    rd(8'h0C);
    chk("ph pre", q[4:3], 32'h1);
    chk("short", charge_current_ma_o, 32'h64);
    vbat_mv_i <= 13'hDAC;
    cyc(10);
    ichg_ma_i <= 12'h64;
    vbat_mv_i <= 13'h1036;
    in_regulation_i <= 1'b1;
    cyc(20);
    chk("no term", host_event_pin_n_o, 32'h1);
    in_regulation_i <= 1'b0;
    evt_len();
    chk("done evt", n, 32'h64);
    rd(8'h0C);
    chk("ph done", q[4:3], 32'h3);
    chk("ind done", charge_indicator_pin_o, 32'h1);
    vbat_mv_i <= 13'hFA0;
    cyc(10);
    rd(8'h0C);
    chk("recharge", q[4:3], 32'h2);
    therm_chg_ok_i <= 1'b0;
    evt_len();
    chk("fault evt", n, 32'h64);
    m = charge_indicator_pin_o;
    n = 0;
    do begin
      @(posedge clk_i);
      n++;
    end while (charge_indicator_pin_o === m && n < 6000);
    chk("blink", charge_indicator_pin_o, {31'h0, ~m});
    therm_chg_ok_i <= 1'b1;
    input_good_i <= 1'b0;
    vin_mv_i <= 13'hBB8;
    vbat_mv_i <= 13'hED8;
    wr(8'h00, 32'h4012);
    cyc(250);
    chk("src early", source_mode_o, 32'h0);
    cyc(100);
    chk("src on", source_mode_o, 32'h1);
    chk("src pwm", source_pwm_o, 32'h1);
    rd(8'h0C);
    chk("src stat", q[2:0], 32'h7);
    vbat_mv_i <= 13'hAF0;
    cyc(4);
    chk("src lowbat", source_mode_o, 32'h0);
    wr(8'h00, 32'h4018);
    rd(8'h0C);
    chk("host mode", q[5], 32'h0);
    report_and_stop();
  end
endmodule
bind cmc_charger_mode_control cmc_asserts i_cmc_asserts (.*);
`default_nettype wire
